// >>> core/mode_reg_pkg.sv
package mode_reg_pkg;
    // mode addresses
    localparam logic [7:0] ADDR_DEVICE_INFORMATION = 8'h00;
    localparam logic [7:0] ADDR_FEATURE_ONE = 8'h01;
    localparam logic [7:0] ADDR_FEATURE_TWO = 8'h02;
    // device_information fields
    localparam int INFO_AUTO_INIT_BIT = 0;
    localparam int INFO_ZQ_LO = 3;
    localparam int INFO_ALT_WL_BIT = 6;
    localparam int INFO_LOW_RL_BIT = 7;
    // zq self-test codes
    localparam logic [1:0] ZQ_NOT_SUPPORTED = 2'h0;
    localparam logic [1:0] ZQ_TIED_SUPPLY = 2'h1;
    localparam logic [1:0] ZQ_SHORT_GND = 2'h2;
    localparam logic [1:0] ZQ_GOOD = 2'h3;
    // feature_one fields and reset
    localparam int F1_WR_LO = 5;
    localparam logic [2:0] BURST_LENGTH_EIGHT = 3'h3;
    localparam logic [2:0] WR_CODE_DEFAULT = 3'h0;
    localparam logic [7:0] F1_WRITE_MASK = 8'hE7;
    // feature_two fields and reset
    localparam int F2_WR_LEVEL_BIT = 7;
    localparam int F2_WRITE_LATENCY_SET_SELECT_BIT = 6;
    localparam int F2_WR_EXT_BIT = 4;
    localparam logic [7:0] F2_WRITE_MASK = 8'hDF;
    localparam logic [7:0] F2_RESET = 8'h18;
    // burst
    localparam logic [2:0] BURST_LAST_BEAT = 3'h7;
    localparam logic [4:0] WR_CYCLES_RESERVED = 5'h00;

    typedef struct packed {
        logic level_enable;
        logic wl_set_b;
        logic wr_ext;
        logic [3:0] latency_code;
    } feature_two_s;

    typedef struct packed {
        logic valid;
        logic [2:0] column;
    } beat_s;
endpackage

// >>> core/mode_reg_feature.sv
// Behaviour
// - info bit 0 reads 1 while auto-init runs, 0 when done
// - info bits 4:3 report zq self-test: 00 none, 01 supply/float, 10 ground
// - zq field reads 11 when self-test found a resistor with no error
// - zq field updates only when zq init calibration completes
// - possible assembly error: factory trim, later zq calibrations ignored
// - zq tied to ca supply reports 01
// - info bit 6 reports alternate write-latency set support
// - info bit 7 reports read latency 3 support up to 166 MHz
// - without extension, codes 001,100,110,111 give 3,6,8,9 recovery cycles
// - with extension, 000,001,010,100,110 give 10,11,12,14,16; default 10
// - recovery count sets cycles from write burst end to precharge start
// - recovery range extension held in feature_two bit 4
// - eight-beat burst starts at column bits 2:1 times two, wraps mod 8
// - column bit zero taken as zero for burst ordering
// - feature_two at 02h: level, wl select, ext, latency; bit 5 reserved
// - feature_one at 01h: recovery 7:5, burst 2:0, bits 4:3 reserved
// - reserved bits written as zero and read back as zero
// - writes to read-only registers have no effect
// - read of write-only or reserved register still strobes, data undefined
`timescale 1ns/10ps
module mode_reg_feature
    import mode_reg_pkg::*;
#(
    parameter logic ALT_WL_SUPPORT = 1'b1,
    parameter logic LOW_RL_SUPPORT = 1'b1
)
(
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST,
    // mode register commands
    input wire logic i_mrw,
    input wire logic i_mrr,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rstrobe,
    // device status
    input wire logic i_init_done,
    input wire logic i_zq_init_done,
    input wire logic [1:0] i_zq_result,
    output logic o_factory_trim,
    // write with auto-precharge
    input wire logic i_wr_ap_start,
    input wire logic [3:1] i_column,
    output logic [2:0] o_beat_column,
    output logic o_beat_valid,
    output logic o_precharge,
    // decoded settings
    output logic [4:0] o_wr_cycles,
    output feature_two_s o_feature_two
);

    function automatic logic [4:0] wr_decode(input logic ext, input logic [2:0] code);
        logic [4:0] n;
        n = WR_CYCLES_RESERVED;
        if (!ext)
        begin
            unique case (code)
                3'h1: n = 5'h03;
                3'h4: n = 5'h06;
                3'h6: n = 5'h08;
                3'h7: n = 5'h09;
                default: n = WR_CYCLES_RESERVED;
            endcase
        end
        else
        begin
            unique case (code)
                3'h0: n = 5'h0A;
                3'h1: n = 5'h0B;
                3'h2: n = 5'h0C;
                3'h4: n = 5'h0E;
                3'h6: n = 5'h10;
                default: n = WR_CYCLES_RESERVED;
            endcase
        end
        return n;
    endfunction

    // register state
    logic [2:0] wr_code, next_wr_code;
    logic [2:0] burst_len, next_burst_len;
    logic [7:0] feat2, next_feat2;
    logic [1:0] zq_info, next_zq_info;
    logic zq_locked, next_zq_locked;
    logic [7:0] rdata, next_rdata;
    logic rstrobe, next_rstrobe;

    always_comb
    begin
        next_wr_code = wr_code;
        next_burst_len = burst_len;
        next_feat2 = feat2;
        next_zq_info = zq_info;
        next_zq_locked = zq_locked;
        next_rdata = 8'h00;
        next_rstrobe = i_mrr;
        if (i_mrw && i_addr == ADDR_FEATURE_ONE)
        begin
            next_wr_code = i_wdata[F1_WR_LO +: 3];
            next_burst_len = BURST_LENGTH_EIGHT;
        end
        if (i_mrw && i_addr == ADDR_FEATURE_TWO)
            next_feat2 = i_wdata & F2_WRITE_MASK;
        // device_information writes fall through untouched
        if (i_zq_init_done && !zq_locked)
        begin
            next_zq_info = i_zq_result;
            // either 01 or 10 may be a misassembled pin
            next_zq_locked = (i_zq_result == ZQ_TIED_SUPPLY)
                || (i_zq_result == ZQ_SHORT_GND);
        end
        if (i_mrr && i_addr == ADDR_DEVICE_INFORMATION)
        begin
            next_rdata[INFO_AUTO_INIT_BIT] = !i_init_done;
            next_rdata[INFO_ZQ_LO +: 2] = zq_info;
            next_rdata[INFO_ALT_WL_BIT] = ALT_WL_SUPPORT;
            next_rdata[INFO_LOW_RL_BIT] = LOW_RL_SUPPORT;
        end
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            wr_code <= WR_CODE_DEFAULT;
            burst_len <= BURST_LENGTH_EIGHT;
            feat2 <= F2_RESET;
            zq_info <= ZQ_NOT_SUPPORTED;
            zq_locked <= 1'b0;
            rdata <= 8'h00;
            rstrobe <= 1'b0;
        end
        else
        begin
            wr_code <= next_wr_code;
            burst_len <= next_burst_len;
            feat2 <= next_feat2;
            zq_info <= next_zq_info;
            zq_locked <= next_zq_locked;
            rdata <= next_rdata;
            rstrobe <= next_rstrobe;
        end
    end

    // burst and auto-precharge timing
    typedef enum {IDLE, BURST, RECOVER} ap_state_e;
    ap_state_e state, next_state;
    beat_s beat, next_beat;
    logic [2:0] beat_count, next_beat_count;
    logic [4:0] rec_count, next_rec_count;
    logic precharge, next_precharge;
    logic [4:0] wr_cycles;

    assign wr_cycles = wr_decode(feat2[F2_WR_EXT_BIT], wr_code);

    always_comb
    begin
        next_state = state;
        next_beat = beat;
        next_beat_count = beat_count;
        next_rec_count = rec_count;
        next_precharge = 1'b0;
        unique case (state)
            IDLE:
            begin
                next_beat.valid = 1'b0;
                if (i_wr_ap_start)
                begin
                    next_state = BURST;
                    next_beat.valid = 1'b1;
                    next_beat.column = {i_column[2:1], 1'b0};
                    next_beat_count = 3'h0;
                end
            end
            BURST:
            begin
                next_beat.column = beat.column + 3'h1;
                next_beat_count = beat_count + 3'h1;
                if (beat_count == BURST_LAST_BEAT)
                begin
                    next_beat.valid = 1'b0;
                    next_state = RECOVER;
                    next_rec_count = wr_cycles;
                end
            end
            RECOVER:
            begin
                // reserved codes give zero: precharge at once
                if (rec_count <= 5'h01)
                begin
                    next_precharge = 1'b1;
                    next_state = IDLE;
                end
                else
                    next_rec_count = rec_count - 5'h01;
            end
        endcase
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            state <= IDLE;
            beat <= '0;
            beat_count <= 3'h0;
            rec_count <= 5'h00;
            precharge <= 1'b0;
            o_wr_cycles <= 5'h00;
            o_feature_two <= '0;
            o_factory_trim <= 1'b0;
        end
        else
        begin
            state <= next_state;
            beat <= next_beat;
            beat_count <= next_beat_count;
            rec_count <= next_rec_count;
            precharge <= next_precharge;
            o_wr_cycles <= wr_cycles;
            o_feature_two <= '{feat2[F2_WR_LEVEL_BIT], feat2[F2_WRITE_LATENCY_SET_SELECT_BIT],
                feat2[F2_WR_EXT_BIT], feat2[3:0]};
            o_factory_trim <= next_zq_locked;
        end
    end

    assign o_rdata = rdata;
    assign o_rstrobe = rstrobe;
    assign o_beat_column = beat.column;
    assign o_beat_valid = beat.valid;
    assign o_precharge = precharge;

    chk_info_read: assert property (@(posedge I_MCLK) disable iff (I_RST)
        i_mrr && i_addr == ADDR_DEVICE_INFORMATION |=> o_rdata[0] == !$past(i_init_done))
        else $error("auto-init bit wrong");
    chk_read_strobe: assert property (@(posedge I_MCLK) disable iff (I_RST)
        i_mrr |=> o_rstrobe)
        else $error("read gave no strobe");
    chk_reserved_zero: assert property (@(posedge I_MCLK) disable iff (I_RST)
        o_rstrobe |-> o_rdata[5] == 1'b0 && o_rdata[2:1] == 2'h0)
        else $error("reserved bits not zero");
    chk_zq_hold: assert property (@(posedge I_MCLK) disable iff (I_RST)
        !i_zq_init_done |=> $stable(zq_info))
        else $error("zq field changed without calibration");
    chk_trim_lock: assert property (@(posedge I_MCLK) disable iff (I_RST)
        zq_locked |=> $stable(zq_info) && zq_locked)
        else $error("calibration not ignored");
    sequence burst_start;
        state == IDLE && i_wr_ap_start;
    endsequence
    chk_burst_first: assert property (@(posedge I_MCLK) disable iff (I_RST)
        burst_start |=> o_beat_valid && o_beat_column == {$past(i_column[2:1]), 1'b0}
            ##1 o_beat_column == $past(o_beat_column) + 3'h1)
        else $error("burst order wrong");
    chk_burst_len: assert property (@(posedge I_MCLK) disable iff (I_RST)
        burst_start |=> o_beat_valid [*8] ##1 !o_beat_valid)
        else $error("burst not eight beats");
    chk_wr_decode: assert property (@(posedge I_MCLK) disable iff (I_RST)
        feat2[F2_WR_EXT_BIT] && wr_code == 3'h6 |-> wr_cycles == 5'h10)
        else $error("recovery decode wrong");
    chk_ro_write: assert property (@(posedge I_MCLK) disable iff (I_RST)
        i_mrw && i_addr == ADDR_DEVICE_INFORMATION |=> $stable(feat2) && $stable(wr_code))
        else $error("read-only write had effect");

    sequence info_read;
        i_mrr && i_addr == ADDR_DEVICE_INFORMATION;
    endsequence
    sequence zq_capture;
        i_zq_init_done && !zq_locked;
    endsequence
    sequence feature_one_write;
        i_mrw && i_addr == ADDR_FEATURE_ONE;
    endsequence
    sequence feature_two_write;
        i_mrw && i_addr == ADDR_FEATURE_TWO;
    endsequence
    sequence burst_last;
        state == BURST && beat_count == BURST_LAST_BEAT;
    endsequence

    // read side
    chk_info_flags: assert property (@(posedge I_MCLK) disable iff (I_RST)
        info_read |=> o_rdata[INFO_LOW_RL_BIT] == LOW_RL_SUPPORT
            && o_rdata[INFO_ALT_WL_BIT] == ALT_WL_SUPPORT)
        else $error("support bits wrong");
    chk_zq_report: assert property (@(posedge I_MCLK) disable iff (I_RST)
        info_read |=> o_rdata[INFO_ZQ_LO +: 2] == $past(zq_info))
        else $error("zq field not reported");
    chk_idle_quiet: assert property (@(posedge I_MCLK) disable iff (I_RST)
        !i_mrr |=> !o_rstrobe && o_rdata == 8'h00)
        else $error("strobe or data without read");

    // zq self-test capture
    chk_zq_capture: assert property (@(posedge I_MCLK) disable iff (I_RST)
        zq_capture |=> zq_info == $past(i_zq_result))
        else $error("zq result not taken");
    chk_supply_lock: assert property (@(posedge I_MCLK) disable iff (I_RST)
        i_zq_init_done && !zq_locked && i_zq_result == ZQ_TIED_SUPPLY |=> zq_locked && o_factory_trim)
        else $error("supply tie did not lock");
    chk_good_open: assert property (@(posedge I_MCLK) disable iff (I_RST)
        i_zq_init_done && !zq_locked && i_zq_result == ZQ_GOOD |=> !zq_locked)
        else $error("good pin locked calibration");

    // feature registers
    chk_f1_store: assert property (@(posedge I_MCLK) disable iff (I_RST)
        feature_one_write |=> wr_code == $past(i_wdata[F1_WR_LO +: 3])
            && burst_len == BURST_LENGTH_EIGHT)
        else $error("feature_one not stored");
    chk_f2_store: assert property (@(posedge I_MCLK) disable iff (I_RST)
        feature_two_write |=> feat2[F2_WR_LEVEL_BIT] == $past(i_wdata[F2_WR_LEVEL_BIT])
            && feat2[F2_WR_EXT_BIT] == $past(i_wdata[F2_WR_EXT_BIT]))
        else $error("feature_two not stored");
    chk_f2_reserved: assert property (@(posedge I_MCLK) disable iff (I_RST)
        feature_two_write |=> feat2[5] == 1'b0)
        else $error("feature_two reserved bit kept");
    chk_wr_base: assert property (@(posedge I_MCLK) disable iff (I_RST)
        !feat2[F2_WR_EXT_BIT] && wr_code == 3'h7 |-> wr_cycles == 5'h09)
        else $error("base recovery decode wrong");

    // burst order and precharge; bursts never abut, precharge sits between
    chk_burst_wrap: assert property (@(posedge I_MCLK) disable iff (I_RST)
        o_beat_valid && $past(o_beat_valid) |-> o_beat_column == $past(o_beat_column) + 3'h1)
        else $error("burst does not wrap");
    chk_column_zero: assert property (@(posedge I_MCLK) disable iff (I_RST)
        burst_start |=> !o_beat_column[0])
        else $error("column bit zero not cleared");
    chk_recover_load: assert property (@(posedge I_MCLK) disable iff (I_RST)
        burst_last |=> state == RECOVER && rec_count == $past(wr_cycles))
        else $error("recovery count not loaded");
    chk_precharge_pulse: assert property (@(posedge I_MCLK) disable iff (I_RST)
        o_precharge |=> !o_precharge)
        else $error("precharge longer than a cycle");
    chk_precharge_source: assert property (@(posedge I_MCLK) disable iff (I_RST)
        o_precharge |-> $past(state) == RECOVER)
        else $error("precharge outside recovery");

endmodule

// >>> testbench/mode_ctrl_model.sv
`timescale 1ns/10ps
module mode_ctrl_model
    import mode_reg_pkg::*;
(
    // clock
    input wire logic I_MCLK,
    // mode register commands
    output logic o_mrw,
    output logic o_mrr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial
    begin
        o_mrw = 1'b0;
        o_mrr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic mrw(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ADDR_FEATURE_ONE)
            v = {d[7:5], 2'h0, BURST_LENGTH_EIGHT};
        if (a == ADDR_FEATURE_TWO)
            v[5] = 1'b0;
        @(posedge I_MCLK);
        #1;
        o_addr = a;
        o_wdata = v;
        o_mrw = 1'b1;
        @(posedge I_MCLK);
        #1;
        o_mrw = 1'b0;
        // released data must not look like the last value
        o_wdata = ~v;
    endtask
    task automatic mrr(input logic [7:0] a);
        @(posedge I_MCLK);
        #1;
        o_addr = a;
        o_mrr = 1'b1;
        @(posedge I_MCLK);
        #1;
        o_mrr = 1'b0;
        o_addr = ~a;
    endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/10ps
module tb
    import mode_reg_pkg::*;
;
    logic I_MCLK = 1'b0;
    logic I_RST = 1'b1;
    logic mrw, mrr, rstrobe, init_done, zq_done, trim, ap, bval, pre;
    logic [7:0] addr, wdata, rdata, w;
    logic [1:0] zq_res;
    logic [3:1] col;
    logic [2:0] bcol, c;
    logic [4:0] wrc;
    feature_two_s f2;
    int bad_count = 0;
    int n_tests = 0;
    int d, n;
    initial
    begin
        forever #50 I_MCLK = ~I_MCLK;
    end
    mode_ctrl_model i_ctrl (.I_MCLK(I_MCLK), .o_mrw(mrw), .o_mrr(mrr), .o_addr(addr),
        .o_wdata(wdata));
    mode_reg_feature i_dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .i_mrw(mrw), .i_mrr(mrr),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rstrobe(rstrobe),
        .i_init_done(init_done), .i_zq_init_done(zq_done), .i_zq_result(zq_res),
        .o_factory_trim(trim), .i_wr_ap_start(ap), .i_column(col), .o_beat_column(bcol),
        .o_beat_valid(bval), .o_precharge(pre), .o_wr_cycles(wrc), .o_feature_two(f2));
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [4:0] wr_exp(input logic e, input logic [2:0] k);
        case ({e, k})
            4'h1: return 5'h03;
            4'h4: return 5'h06;
            4'h6: return 5'h08;
            4'h7: return 5'h09;
            4'h8: return 5'h0A;
            4'h9: return 5'h0B;
            4'hA: return 5'h0C;
            4'hC: return 5'h0E;
            4'hE: return 5'h10;
            default: return 5'h00;
        endcase
    endfunction
    task automatic read_info(input logic [1:0] zq, input logic busy);
        i_ctrl.mrr(ADDR_DEVICE_INFORMATION);
        check({7'h00, rstrobe}, 8'h01, "strobe");
        check(rdata, {2'h3, 1'b0, zq, 2'h0, busy}, "info");
    endtask
    task automatic zq(input logic [1:0] r);
        @(posedge I_MCLK);
        #1;
        zq_res = r;
        zq_done = 1'b1;
        @(posedge I_MCLK);
        #1;
        zq_done = 1'b0;
        // result left wrong between pulses: only the pulse may latch it
        zq_res = ~r;
    endtask
    initial
    begin
        #2000000;
        bad_count++;
        $display("wrong value at %0t: watchdog", $time);
        results;
    end
    initial
    begin
        void'($urandom(32'h0A8D674A));
        {init_done, zq_done, zq_res, ap, col} = 8'h00;
        repeat (20) @(posedge I_MCLK);
        #1;
        I_RST = 1'b0;
        repeat (2) @(posedge I_MCLK);
        #1;
        check({3'h0, wrc}, 8'h0A, "wr reset");
        check({1'b0, f2}, F2_RESET, "f2 reset");
        read_info(2'h0, 1'b1);
        init_done = 1'b1;
        d = 0;
        do
        begin
            i_ctrl.mrr(ADDR_DEVICE_INFORMATION);
            d++;
        end while (rdata[0] !== 1'b0 && d < 20);
        check({7'h00, rdata[0]}, 8'h00, "poll");
        read_info(2'h0, 1'b0);
        $display("test auto-init done");
        zq(2'h3);
        read_info(2'h3, 1'b0);
        check({7'h00, trim}, 8'h00, "trim");
        zq(2'h1);
        read_info(2'h1, 1'b0);
        check({7'h00, trim}, 8'h01, "trim");
        zq(2'h2);
        read_info(2'h1, 1'b0);
        $display("test zq done");
        i_ctrl.mrw(ADDR_DEVICE_INFORMATION, 8'hFF);
        read_info(2'h1, 1'b0);
        i_ctrl.mrr(ADDR_FEATURE_ONE);
        check({7'h00, rstrobe}, 8'h01, "wo strobe");
        $display("test access done");
        for (int e = 0; e < 2; e++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                // reserved recovery codes must not be written
                if (wr_exp(e[0], k[2:0]) == 5'h00)
                    continue;
                w = 8'($urandom);
                w[4] = e[0];
                i_ctrl.mrw(ADDR_FEATURE_TWO, w);
                i_ctrl.mrw(ADDR_FEATURE_ONE, {k[2:0], 5'($urandom)});
                repeat (2) @(posedge I_MCLK);
                #1;
                check({3'h0, wrc}, {3'h0, wr_exp(e[0], k[2:0])}, "wr");
                check({1'b0, f2}, {1'b0, w[7:6], w[4:0]}, "f2");
            end
        end
        $display("test decode done");
        for (int i = 0; i < 8; i++)
        begin
            do
                c = 3'($urandom);
            while (wr_exp(1'b1, c) == 5'h00);
            i_ctrl.mrw(ADDR_FEATURE_ONE, {c, 5'h00});
            n = int'(wr_exp(1'b1, c));
            col = 3'($urandom);
            ap = 1'b1;
            @(posedge I_MCLK);
            #1;
            ap = 1'b0;
            for (int k = 0; k < 8; k++)
            begin
                check({7'h00, bval}, 8'h01, "beat valid");
                check({5'h00, bcol}, {5'h00, 3'({col[2:1], 1'b0} + k)}, "beat");
                @(posedge I_MCLK);
                #1;
            end
            check({7'h00, bval}, 8'h00, "beat end");
            d = 0;
            while (pre !== 1'b1 && d < 40)
            begin
                d++;
                @(posedge I_MCLK);
                #1;
            end
            check({7'h00, pre}, 8'h01, "precharge");
            check({7'h00, 1'(d == n)}, 8'h01, "recovery");
            @(posedge I_MCLK);
            #1;
            check({7'h00, pre}, 8'h00, "precharge end");
        end
        $display("test burst done");
        results;
    end
endmodule
